// [ciac_pkg.sv]
package ciac_pkg;

   // register indices; byte address is four times the index
   localparam logic [5:0]  IDX_FLAG        = 6'h03;
   localparam logic [5:0]  IDX_ENABLE      = 6'h04;
   localparam logic [5:0]  IDX_CAPTURE     = 6'h0b;
   localparam logic [5:0]  IDX_AUX         = 6'h20;
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  ADDR_FLAG       = {IDX_FLAG, 2'b00};
   localparam logic [7:0]  ADDR_ENABLE     = {IDX_ENABLE, 2'b00};
   localparam logic [7:0]  ADDR_CAPTURE    = {IDX_CAPTURE, 2'b00};
   localparam logic [7:0]  ADDR_AUX        = {IDX_AUX, 2'b00};

   // flag and enable bit positions
   localparam int          BIT_BUS_ERR     = 7;
   localparam int          BIT_ARB_LOST    = 6;
   localparam int          BIT_ERR_PASSIVE = 5;
   localparam int          BIT_WAKEUP      = 4;
   localparam int          BIT_OVERRUN     = 3;
   localparam int          BIT_ERR_WARN    = 2;
   localparam int          BIT_TX_DONE     = 1;
   localparam int          BIT_RX_PENDING  = 0;

   // auxiliary control register bits
   localparam int          BIT_AUX_SLEEP   = 0;
   localparam int          BIT_AUX_RELEASE = 1;

   localparam int          POS_W           = 5;

   // reset values
   localparam logic [7:0]  RST_ENABLE      = 8'h00;
   localparam logic [7:0]  RST_FLAG        = 8'h00;
   localparam logic [4:0]  RST_CAPTURE     = 5'h00;

   // axi responses
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   typedef struct packed {
      logic bus_error;
      logic arb_lost;
      logic wake_activity;
   } ciac_evt_s;

   typedef struct packed {
      logic err_passive;
      logic err_status;
      logic bus_status;
      logic overrun;
      logic tx_buf_free;
      logic rx_buf_full;
      logic bus_active;
   } ciac_stat_s;

endpackage

// [ciac_top.sv]
`timescale 1ns/10ps

module ciac_top (
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic [2:0]            s_axi_awprot,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic [2:0]            s_axi_arprot,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire ciac_pkg::ciac_evt_s   evt,
   input  wire ciac_pkg::ciac_stat_s  stat,
   input  wire logic [4:0]            bit_pos,
   output logic                       irq_n,
   output logic                       sleep_mode,
   output logic                       rx_release
);

   typedef enum logic [1:0] {
      WR_COLLECT = 2'b01,
      WR_RESP    = 2'b10
   } ciac_wr_e;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_RESP = 2'b10
   } ciac_rd_e;

   function automatic logic ciac_mapped(input logic [7:0] addr);
      ciac_mapped = 1'b0;
      if (addr == ciac_pkg::ADDR_FLAG) begin
         ciac_mapped = 1'b1;
      end else if (addr == ciac_pkg::ADDR_ENABLE) begin
         ciac_mapped = 1'b1;
      end else if (addr == ciac_pkg::ADDR_CAPTURE) begin
         ciac_mapped = 1'b1;
      end else if (addr == ciac_pkg::ADDR_AUX) begin
         ciac_mapped = 1'b1;
      end
   endfunction

   // write channel state
   ciac_wr_e      wr_state_reg;
   ciac_wr_e      wr_state_next;
   logic          aw_have_reg;
   logic          aw_have_next;
   logic          w_have_reg;
   logic          w_have_next;
   logic [7:0]    awaddr_reg;
   logic [7:0]    awaddr_next;
   logic [7:0]    wdata_reg;
   logic [7:0]    wdata_next;
   logic          wstrb0_reg;
   logic          wstrb0_next;
   logic [1:0]    bresp_reg;
   logic [1:0]    bresp_next;
   logic          wr_commit;

   // read channel state
   ciac_rd_e      rd_state_reg;
   ciac_rd_e      rd_state_next;
   logic [31:0]   rdata_reg;
   logic [31:0]   rdata_next;
   logic [1:0]    rresp_reg;
   logic [1:0]    rresp_next;
   logic          rd_take;
   logic          rd_flag;
   logic          rd_capture;

   // block state
   logic [7:0]    irq_enable_reg;
   logic [7:0]    irq_enable_next;
   logic [7:0]    irq_flag_reg;
   logic [7:0]    irq_flag_next;
   logic [4:0]    arb_lost_capture_reg;
   logic [4:0]    arb_lost_capture_next;
   logic          capture_armed_reg;
   logic          capture_armed_next;
   logic          sleep_reg;
   logic          sleep_next;
   logic          release_reg;
   logic          release_next;
   logic          rx_hide_reg;
   logic          rx_hide_next;
   logic          irq_n_reg;
   logic          irq_n_next;
   ciac_pkg::ciac_stat_s  stat_q_reg;
   ciac_pkg::ciac_stat_s  stat_q_next;

   logic          wr_enable;
   logic          wr_aux;
   logic          sleep_refused;
   logic [7:0]    flag_set;

   // write channel
   always_comb begin
      wr_state_next = wr_state_reg;
      aw_have_next  = aw_have_reg;
      w_have_next   = w_have_reg;
      awaddr_next   = awaddr_reg;
      wdata_next    = wdata_reg;
      wstrb0_next   = wstrb0_reg;
      bresp_next    = bresp_reg;
      wr_commit     = 1'b0;
      case (wr_state_reg)
         WR_COLLECT: begin
            // address and data may arrive in either order
            if (s_axi_awvalid && !aw_have_reg) begin
               aw_have_next = 1'b1;
               awaddr_next  = s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_have_reg) begin
               w_have_next = 1'b1;
               wdata_next  = s_axi_wdata[7:0];
               wstrb0_next = s_axi_wstrb[0];
            end
            // read-only targets answer okay and change nothing
            if (aw_have_reg && w_have_reg) begin
               wr_commit     = 1'b1;
               aw_have_next  = 1'b0;
               w_have_next   = 1'b0;
               bresp_next    = ciac_mapped(awaddr_reg) ? ciac_pkg::RESP_OKAY
                                                       : ciac_pkg::RESP_SLVERR;
               wr_state_next = WR_RESP;
            end
         end
         WR_RESP: begin
            if (s_axi_bready) begin
               wr_state_next = WR_COLLECT;
            end
         end
         default: begin
            wr_state_next = WR_COLLECT;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_state_reg <= WR_COLLECT;
         aw_have_reg  <= 1'b0;
         w_have_reg   <= 1'b0;
         awaddr_reg   <= 8'h00;
         wdata_reg    <= 8'h00;
         wstrb0_reg   <= 1'b0;
         bresp_reg    <= ciac_pkg::RESP_OKAY;
      end else begin
         wr_state_reg <= wr_state_next;
         aw_have_reg  <= aw_have_next;
         w_have_reg   <= w_have_next;
         awaddr_reg   <= awaddr_next;
         wdata_reg    <= wdata_next;
         wstrb0_reg   <= wstrb0_next;
         bresp_reg    <= bresp_next;
      end
   end

   assign s_axi_awready = (wr_state_reg == WR_COLLECT) && !aw_have_reg;
   assign s_axi_wready  = (wr_state_reg == WR_COLLECT) && !w_have_reg;
   assign s_axi_bvalid  = (wr_state_reg == WR_RESP);
   assign s_axi_bresp   = bresp_reg;

   // only byte lane 0 carries register data
   assign wr_enable = wr_commit && wstrb0_reg && (awaddr_reg == ciac_pkg::ADDR_ENABLE);
   assign wr_aux    = wr_commit && wstrb0_reg && (awaddr_reg == ciac_pkg::ADDR_AUX);

   // read channel
   assign rd_take    = (rd_state_reg == RD_IDLE) && s_axi_arvalid;
   assign rd_flag    = rd_take && (s_axi_araddr == ciac_pkg::ADDR_FLAG);
   assign rd_capture = rd_take && (s_axi_araddr == ciac_pkg::ADDR_CAPTURE);

   always_comb begin
      rd_state_next = rd_state_reg;
      rdata_next    = rdata_reg;
      rresp_next    = rresp_reg;
      case (rd_state_reg)
         RD_IDLE: begin
            if (s_axi_arvalid) begin
               rd_state_next = RD_RESP;
               // unused and reserved bits read as zero
               rdata_next    = 32'h0000_0000;
               rresp_next    = ciac_mapped(s_axi_araddr) ? ciac_pkg::RESP_OKAY
                                                         : ciac_pkg::RESP_SLVERR;
               // flags go out as they were before this read clears them
               if (s_axi_araddr == ciac_pkg::ADDR_FLAG) begin
                  rdata_next[7:0] = irq_flag_reg;
               end else if (s_axi_araddr == ciac_pkg::ADDR_ENABLE) begin
                  rdata_next[7:0] = irq_enable_reg;
               end else if (s_axi_araddr == ciac_pkg::ADDR_CAPTURE) begin
                  rdata_next[4:0] = arb_lost_capture_reg;
               end else if (s_axi_araddr == ciac_pkg::ADDR_AUX) begin
                  rdata_next[ciac_pkg::BIT_AUX_SLEEP] = sleep_reg;
               end
            end
         end
         RD_RESP: begin
            if (s_axi_rready) begin
               rd_state_next = RD_IDLE;
            end
         end
         default: begin
            rd_state_next = RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rd_state_reg <= RD_IDLE;
         rdata_reg    <= 32'h0000_0000;
         rresp_reg    <= ciac_pkg::RESP_OKAY;
      end else begin
         rd_state_reg <= rd_state_next;
         rdata_reg    <= rdata_next;
         rresp_reg    <= rresp_next;
      end
   end

   assign s_axi_arready = (rd_state_reg == RD_IDLE);
   assign s_axi_rvalid  = (rd_state_reg == RD_RESP);
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   // sleep request refused while the bus is busy or anything is pending
   assign sleep_refused = wr_aux && wdata_reg[ciac_pkg::BIT_AUX_SLEEP] && !sleep_reg
                          && (stat.bus_active || (|irq_flag_reg));

   // event sources, each gated by its own enable bit
   always_comb begin
      flag_set = 8'h00;
      // edge events compare against last cycle's status
      flag_set[ciac_pkg::BIT_BUS_ERR] = evt.bus_error
         && irq_enable_reg[ciac_pkg::BIT_BUS_ERR];
      flag_set[ciac_pkg::BIT_ARB_LOST] = evt.arb_lost && capture_armed_reg
         && irq_enable_reg[ciac_pkg::BIT_ARB_LOST];
      flag_set[ciac_pkg::BIT_ERR_PASSIVE] = (stat.err_passive != stat_q_reg.err_passive)
         && irq_enable_reg[ciac_pkg::BIT_ERR_PASSIVE];
      flag_set[ciac_pkg::BIT_WAKEUP] = ((sleep_reg && evt.wake_activity) || sleep_refused)
         && irq_enable_reg[ciac_pkg::BIT_WAKEUP];
      flag_set[ciac_pkg::BIT_OVERRUN] = stat.overrun && !stat_q_reg.overrun
         && irq_enable_reg[ciac_pkg::BIT_OVERRUN];
      flag_set[ciac_pkg::BIT_ERR_WARN] = ((stat.err_status != stat_q_reg.err_status)
         || (stat.bus_status != stat_q_reg.bus_status))
         && irq_enable_reg[ciac_pkg::BIT_ERR_WARN];
      flag_set[ciac_pkg::BIT_TX_DONE] = stat.tx_buf_free && !stat_q_reg.tx_buf_free
         && irq_enable_reg[ciac_pkg::BIT_TX_DONE];
   end

   // flags, enables, capture and sleep
   always_comb begin
      irq_enable_next       = irq_enable_reg;
      capture_armed_next    = capture_armed_reg;
      arb_lost_capture_next = arb_lost_capture_reg;
      sleep_next            = sleep_reg;
      release_next          = 1'b0;
      // history resets to zero, so a status level high out of reset reads as a change
      stat_q_next           = stat;

      if (wr_enable) begin
         irq_enable_next = wdata_reg;
      end

      // a read clears flags 7..1; a new event in that cycle still wins
      irq_flag_next = irq_flag_reg;
      if (rd_flag) begin
         irq_flag_next[7:1] = 7'h00;
      end
      irq_flag_next[7:1] = irq_flag_next[7:1] | flag_set[7:1];

      if (wr_aux && wdata_reg[ciac_pkg::BIT_AUX_RELEASE]) begin
         release_next = 1'b1;
      end
      // the fifo needs a cycle to update, so the flag is hidden twice
      rx_hide_next = release_next;
      // level flag, recomputed every cycle, untouched by reads
      irq_flag_next[ciac_pkg::BIT_RX_PENDING] = stat.rx_buf_full
         && irq_enable_next[ciac_pkg::BIT_RX_PENDING]
         && !release_next && !rx_hide_reg;

      // capture happens even with the flag disabled
      if (rd_capture) begin
         capture_armed_next = 1'b1;
      end
      // a read racing a loss returns the old position and stays disarmed
      if (evt.arb_lost && capture_armed_reg) begin
         arb_lost_capture_next = bit_pos;
         capture_armed_next    = 1'b0;
      end

      // leaving sleep by software raises no flag
      if (wr_aux) begin
         if (!wdata_reg[ciac_pkg::BIT_AUX_SLEEP]) begin
            sleep_next = 1'b0;
         end else if (!sleep_refused) begin
            sleep_next = 1'b1;
         end
      end
      if (sleep_reg && evt.wake_activity) begin
         sleep_next = 1'b0;
      end

      // taken from the next flags so the pin moves with the flag, not a cycle later
      irq_n_next = !(|irq_flag_next);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_enable_reg       <= ciac_pkg::RST_ENABLE;
         irq_flag_reg         <= ciac_pkg::RST_FLAG;
         arb_lost_capture_reg <= ciac_pkg::RST_CAPTURE;
         // armed out of reset so the first loss is recorded
         capture_armed_reg    <= 1'b1;
         sleep_reg            <= 1'b0;
         release_reg          <= 1'b0;
         rx_hide_reg          <= 1'b0;
         irq_n_reg            <= 1'b1;
         stat_q_reg           <= '0;
      end else begin
         irq_enable_reg       <= irq_enable_next;
         irq_flag_reg         <= irq_flag_next;
         arb_lost_capture_reg <= arb_lost_capture_next;
         capture_armed_reg    <= capture_armed_next;
         sleep_reg            <= sleep_next;
         release_reg          <= release_next;
         rx_hide_reg          <= rx_hide_next;
         irq_n_reg            <= irq_n_next;
         stat_q_reg           <= stat_q_next;
      end
   end

   assign irq_n      = irq_n_reg;
   assign sleep_mode = sleep_reg;
   assign rx_release = release_reg;

endmodule

// [ciac_chk.sv]
`timescale 1ns/10ps
module ciac_chk (
   input wire logic                  clk,
   input wire logic                  reset,
   input wire logic                  s_axi_awvalid,
   input wire logic                  s_axi_awready,
   input wire logic                  s_axi_wvalid,
   input wire logic                  s_axi_wready,
   input wire logic                  s_axi_bvalid,
   input wire logic [7:0]            s_axi_araddr,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic [31:0]           s_axi_rdata,
   input wire logic [1:0]            s_axi_rresp,
   input wire logic                  s_axi_rvalid,
   input wire logic                  s_axi_rready,
   input wire ciac_pkg::ciac_evt_s   evt,
   input wire logic                  sleep_mode,
   input wire logic                  rx_release
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer not held");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer off time");
   cap_upper_a: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == ciac_pkg::ADDR_CAPTURE
      |=> s_axi_rdata[31:5] == 27'h0) else $error("capture upper bits not zero");
   bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
      |=> s_axi_rresp == ciac_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   release_pulse_a: assert property (rx_release |=> !rx_release)
      else $error("release longer than one cycle");
   wake_clear_a: assert property (sleep_mode && evt.wake_activity |=> !sleep_mode)
      else $error("activity did not wake");
endmodule
bind ciac_top ciac_chk u_ciac_chk (.*);

// [ciac_host.sv]
`timescale 1ns/10ps
module ciac_host (
   input  wire logic         clk,
   output logic [7:0]        s_axi_awaddr,
   output logic [2:0]        s_axi_awprot,
   output logic              s_axi_awvalid,
   input  wire logic         s_axi_awready,
   output logic [31:0]       s_axi_wdata,
   output logic [3:0]        s_axi_wstrb,
   output logic              s_axi_wvalid,
   input  wire logic         s_axi_wready,
   input  wire logic [1:0]   s_axi_bresp,
   input  wire logic         s_axi_bvalid,
   output logic              s_axi_bready,
   output logic [7:0]        s_axi_araddr,
   output logic [2:0]        s_axi_arprot,
   output logic              s_axi_arvalid,
   input  wire logic         s_axi_arready,
   input  wire logic [31:0]  s_axi_rdata,
   input  wire logic [1:0]   s_axi_rresp,
   input  wire logic         s_axi_rvalid,
   output logic              s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'h1;
   end
   // released payload is inverted so a stale value is never mistaken for live data
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~s_axi_wdata;
         end
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // lag keeps rready low for that many answer cycles, so a stalled answer is exercised
   task automatic rd(input logic [7:0] a, input int lag, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= (lag == 0);
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
         if (s_axi_rvalid === 1'b1 && !s_axi_rready) begin
            lag--;
            if (lag <= 0) begin
               s_axi_rready <= 1'b1;
            end
         end
      end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule

// [ciac_top_tb.sv]
`timescale 1ns/10ps
module ciac_top_tb;
   logic                  clk, reset, irq_n, sleep_mode, rx_release;
   logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                  s_axi_rvalid, s_axi_rready;
   logic [7:0]            s_axi_awaddr, s_axi_araddr;
   logic [2:0]            s_axi_awprot, s_axi_arprot;
   logic [3:0]            s_axi_wstrb;
   logic [31:0]           s_axi_wdata, s_axi_rdata, rd_val;
   logic [1:0]            s_axi_bresp, s_axi_rresp, resp;
   ciac_pkg::ciac_evt_s   evt;
   ciac_pkg::ciac_stat_s  stat;
   logic [4:0]            bit_pos;
   int                    mismatches, samples_checked, hi_cnt, rel_cnt, h0, r0;

   ciac_top u_ciac_top (.*);
   ciac_host u_ciac_host (.*);

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      if (irq_n === 1'b1) hi_cnt <= hi_cnt + 1;
      if (rx_release === 1'b1) rel_cnt <= rel_cnt + 1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      u_ciac_host.rd(a, 0, rd_val, resp);
      chk(rd_val, exp);
      chk({30'h0, resp}, {30'h0, ciac_pkg::RESP_OKAY});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_ciac_host.wr(a, d, resp);
   endtask
   // one cause, then irq level and two flag reads: the second shows what reads clear
   task automatic ev(input logic [2:0] e, input logic [6:0] s, input logic [4:0] p,
                     input logic [7:0] exp);
      @(posedge clk);
      evt <= e;
      stat <= s;
      bit_pos <= p;
      @(posedge clk);
      evt <= 3'h0;
      @(posedge clk);
      chk({31'h0, irq_n}, {31'h0, exp == 8'h0});
      rdc(ciac_pkg::ADDR_FLAG, {24'h0, exp});
      rdc(ciac_pkg::ADDR_FLAG, {24'h0, exp & 8'h01});
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      close_out;
   end

   initial begin
      reset = 1'b1;
      evt = '0;
      stat = '0;
      bit_pos = 5'h0;
      {mismatches, samples_checked, hi_cnt, rel_cnt} = '0;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      rdc(ciac_pkg::ADDR_ENABLE, 32'h0);
      rdc(ciac_pkg::ADDR_CAPTURE, 32'h0);
      chk({31'h0, irq_n}, 32'h1);
      $display("reset test done");
      ev(3'b111, 7'h00, 5'h05, 8'h00);
      wr(ciac_pkg::ADDR_ENABLE, 8'hff);
      rdc(ciac_pkg::ADDR_ENABLE, 32'hff);
      wr(ciac_pkg::ADDR_CAPTURE, 8'h15);
      chk({30'h0, resp}, {30'h0, ciac_pkg::RESP_OKAY});
      rdc(ciac_pkg::ADDR_CAPTURE, 32'h05);
      wr(8'h00, 8'h55);
      chk({30'h0, resp}, {30'h0, ciac_pkg::RESP_SLVERR});
      u_ciac_host.rd(8'h00, 2, rd_val, resp);
      chk({30'h0, resp}, {30'h0, ciac_pkg::RESP_SLVERR});
      chk(rd_val, 32'h0);
      $display("map test done");
      ev(3'b100, 7'h00, 5'h00, 8'h80);
      ev(3'b010, 7'h00, 5'h0b, 8'h40);
      ev(3'b010, 7'h00, 5'h1f, 8'h00);
      rdc(ciac_pkg::ADDR_CAPTURE, 32'h0b);
      ev(3'b010, 7'h00, 5'h1f, 8'h40);
      rdc(ciac_pkg::ADDR_CAPTURE, 32'h1f);
      ev(3'b000, 7'h40, 5'h00, 8'h20);
      ev(3'b000, 7'h00, 5'h00, 8'h20);
      ev(3'b000, 7'h20, 5'h00, 8'h04);
      ev(3'b000, 7'h10, 5'h00, 8'h04);
      ev(3'b000, 7'h08, 5'h00, 8'h0c);
      ev(3'b000, 7'h04, 5'h00, 8'h02);
      ev(3'b000, 7'h00, 5'h00, 8'h00);
      ev(3'b000, 7'h02, 5'h00, 8'h01);
      $display("event test done");
      wr(ciac_pkg::ADDR_ENABLE, 8'hfe);
      chk({31'h0, irq_n}, 32'h1);
      rdc(ciac_pkg::ADDR_FLAG, 32'h00);
      wr(ciac_pkg::ADDR_ENABLE, 8'hff);
      h0 = hi_cnt;
      r0 = rel_cnt;
      wr(ciac_pkg::ADDR_AUX, 8'h02);
      repeat (3) @(posedge clk);
      chk({31'h0, hi_cnt > h0}, 32'h1);
      rdc(ciac_pkg::ADDR_FLAG, 32'h01);
      ev(3'b000, 7'h00, 5'h00, 8'h00);
      wr(ciac_pkg::ADDR_AUX, 8'h02);
      repeat (3) @(posedge clk);
      rdc(ciac_pkg::ADDR_FLAG, 32'h00);
      chk(rel_cnt - r0, 32'h2);
      $display("receive test done");
      ev(3'b000, 7'h01, 5'h00, 8'h00);
      wr(ciac_pkg::ADDR_AUX, 8'h01);
      chk({31'h0, sleep_mode}, 32'h0);
      rdc(ciac_pkg::ADDR_FLAG, 32'h10);
      ev(3'b000, 7'h00, 5'h00, 8'h00);
      wr(ciac_pkg::ADDR_AUX, 8'h01);
      chk({31'h0, sleep_mode}, 32'h1);
      rdc(ciac_pkg::ADDR_AUX, 32'h1);
      ev(3'b001, 7'h00, 5'h00, 8'h10);
      chk({31'h0, sleep_mode}, 32'h0);
      ev(3'b000, 7'h02, 5'h00, 8'h01);
      wr(ciac_pkg::ADDR_AUX, 8'h01);
      chk({31'h0, sleep_mode}, 32'h0);
      rdc(ciac_pkg::ADDR_FLAG, 32'h11);
      $display("sleep test done");
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rdc(ciac_pkg::ADDR_ENABLE, 32'h0);
      chk({31'h0, irq_n}, 32'h1);
      $display("second reset test done");
      close_out;
   end
endmodule
